// file: src/ssgb_top.sv
// second-stage 1-GByte leaf entry decoder with avalon register slave
// Summary of operation
// - dirty bit 9 set once a write-seeking request translates through this entry
// - accessed bit 8 set when the entry is used for a translation
// - dirty and accessed bits ignored while access/dirty enable is 0
// - page size bit 7 at 1 marks a 1-GByte leaf, 0 a directory pointer
// - without 1-GByte large page support the page size bit must be 0
// - ignore-attribute bit ignored when memory type enable clear or table mode legacy
// - ignore-attribute bit applies only to nested walks from coherent devices
// - ignore-attribute 0 uses the attribute table, 1 excludes it
// - bits 5:3 give memory type for coherent second-stage-only or nested walks
// - type codes 0,1,4,5,6 valid; all other codes reserved
// - read and write bits ignored when I/O permission bits are enabled
// - I/O bits disabled: write bit 0 denies write
// - I/O bits disabled: read bit 0 denies read
// - zero-length reads skip the read check when the write bit is 1
// - bits host width-1 to 30 hold the page base; bits 51 down reserved
// - I/O bits enabled: bit 62 at 0 denies write; else bit 62 reserved
// - I/O bits enabled: bit 61 at 0 denies read; else ignored
// - bit 11 selects snooping; reserved 0 without snoop control
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module ssgb_top #(
   parameter int unsigned HOST_ADDR_W = 48
) (
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // avalon-mm slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // walk status
   output logic busy_o,
   output logic done_o
);

   localparam logic [63:0] HOST_MASK = (64'h1 << HOST_ADDR_W) - 64'h1;
   localparam logic [63:0] RSV_HI = ssgb_pkg::RSV_TOP_MASK & ~HOST_MASK;

   ////////////////////////////////////////////////////////////////////////////////
   // byte-lane merge for register writes
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait state, then waitrequest drops for one cycle
   logic ack_r;
   logic ack_nxt;
   logic wait_r;
   logic wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic wr_go;
   logic start_go;

   // register file
   ssgb_pkg::ssgb_ctx_t ctx_r;
   ssgb_pkg::ssgb_ctx_t ctx_nxt;
   ssgb_pkg::ssgb_req_t req_r;
   ssgb_pkg::ssgb_req_t req_nxt;
   logic [63:0] ent_r;
   logic [63:0] ent_nxt;
   logic [63:0] iaddr_r;
   logic [63:0] iaddr_nxt;

   // walk state and results
   ssgb_pkg::ssgb_state_t st_r;
   ssgb_pkg::ssgb_state_t st_nxt;
   ssgb_pkg::ssgb_res_t res_r;
   ssgb_pkg::ssgb_res_t res_nxt;
   logic done_r;
   logic done_nxt;
   logic [63:0] oaddr_r;
   logic [63:0] oaddr_nxt;
   logic [63:0] uent_r;
   logic [63:0] uent_nxt;

   // submodule results
   logic rd_ok_w;
   logic wr_ok_w;
   logic emt_used_w;
   logic emt_rsvd_w;
   logic pat_used_w;
   logic [2:0] mem_type_w;

   // entry checks
   logic leaf;
   logic rsvd_err;
   logic req_ok;
   logic success;
   logic [31:0] stat_word;

   ////////////////////////////////////////////////////////////////////////////////
   // request accepted on first cycle, answered with registered data next cycle
   always_comb begin
      ack_nxt = (avs_read_i || avs_write_i) && !ack_r;
      wait_nxt = !ack_nxt;
      wr_go = avs_write_i && ack_r;
      start_go = wr_go && (avs_address_i == ssgb_pkg::OFF_CMD)
         && avs_byteenable_i[0] && avs_writedata_i[ssgb_pkg::CMD_START_BIT];
      stat_word = {19'h0, done_r, res_r};
      rdata_nxt = rdata_r;
      if (ack_nxt && avs_read_i) begin
         if (avs_address_i == ssgb_pkg::OFF_CMD) begin
            rdata_nxt = {31'h0, st_r == ssgb_pkg::ST_CALC};
         end else if (avs_address_i == ssgb_pkg::OFF_CTX) begin
            rdata_nxt = {20'h0, ctx_r};
         end else if (avs_address_i == ssgb_pkg::OFF_ENT_LO) begin
            rdata_nxt = ent_r[31:0];
         end else if (avs_address_i == ssgb_pkg::OFF_ENT_HI) begin
            rdata_nxt = ent_r[63:32];
         end else if (avs_address_i == ssgb_pkg::OFF_IADDR_LO) begin
            rdata_nxt = iaddr_r[31:0];
         end else if (avs_address_i == ssgb_pkg::OFF_IADDR_HI) begin
            rdata_nxt = iaddr_r[63:32];
         end else if (avs_address_i == ssgb_pkg::OFF_REQ) begin
            rdata_nxt = {29'h0, req_r};
         end else if (avs_address_i == ssgb_pkg::OFF_STAT) begin
            rdata_nxt = stat_word;
         end else if (avs_address_i == ssgb_pkg::OFF_OADDR_LO) begin
            rdata_nxt = oaddr_r[31:0];
         end else if (avs_address_i == ssgb_pkg::OFF_OADDR_HI) begin
            rdata_nxt = oaddr_r[63:32];
         end else if (avs_address_i == ssgb_pkg::OFF_UENT_LO) begin
            rdata_nxt = uent_r[31:0];
         end else if (avs_address_i == ssgb_pkg::OFF_UENT_HI) begin
            rdata_nxt = uent_r[63:32];
         end else begin
            rdata_nxt = ssgb_pkg::RST_WORD; // unmapped reads as zero
         end
      end
   end

   // setup writes; ignored mid-walk so the decode inputs never tear
   always_comb begin
      ctx_nxt = ctx_r;
      req_nxt = req_r;
      ent_nxt = ent_r;
      iaddr_nxt = iaddr_r;
      if (wr_go && (st_r == ssgb_pkg::ST_IDLE)) begin
         if (avs_address_i == ssgb_pkg::OFF_CTX) begin
            ctx_nxt = 12'(be_merge({20'h0, ctx_r}, avs_writedata_i, avs_byteenable_i));
         end else if (avs_address_i == ssgb_pkg::OFF_ENT_LO) begin
            ent_nxt[31:0] = be_merge(ent_r[31:0], avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == ssgb_pkg::OFF_ENT_HI) begin
            ent_nxt[63:32] = be_merge(ent_r[63:32], avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == ssgb_pkg::OFF_IADDR_LO) begin
            iaddr_nxt[31:0] = be_merge(iaddr_r[31:0], avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == ssgb_pkg::OFF_IADDR_HI) begin
            iaddr_nxt[63:32] = be_merge(iaddr_r[63:32], avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == ssgb_pkg::OFF_REQ) begin
            req_nxt = 3'(be_merge({29'h0, req_r}, avs_writedata_i, avs_byteenable_i));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // permission and memory type decode, one registered stage each
   ssgb_perm u_perm (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .entry_i(ent_r),
      .ctx_i(ctx_r),
      .req_i(req_r),
      .rd_ok_o(rd_ok_w),
      .wr_ok_o(wr_ok_w)
   );

   ssgb_memtype u_memtype (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .entry_i(ent_r),
      .ctx_i(ctx_r),
      .emt_used_o(emt_used_w),
      .emt_rsvd_o(emt_rsvd_w),
      .pat_used_o(pat_used_w),
      .mem_type_o(mem_type_w)
   );

   // leaf and reserved checks, translation and flag update
   always_comb begin
      leaf = ent_r[ssgb_pkg::BIT_PAGE_SIZE];
      rsvd_err = (|(ent_r & RSV_HI))
         || (|(ent_r & ssgb_pkg::RSV_LOW_MASK))
         || (!ctx_r.io_rw_enable && ent_r[ssgb_pkg::BIT_IO_WRITE])
         || (!ctx_r.snoop_ctl_support && ent_r[ssgb_pkg::BIT_SNOOP])
         || (!ctx_r.second_stage_large_page_support
             && ent_r[ssgb_pkg::BIT_PAGE_SIZE])
         || emt_rsvd_w;
      req_ok = (!req_r.is_read || rd_ok_w) && (!req_r.is_write || wr_ok_w);
      success = leaf && !rsvd_err && req_ok;
      st_nxt = st_r;
      done_nxt = done_r;
      res_nxt = res_r;
      oaddr_nxt = oaddr_r;
      uent_nxt = uent_r;
      case (st_r)
         ssgb_pkg::ST_IDLE: begin
            if (start_go) begin
               st_nxt = ssgb_pkg::ST_CALC;
               done_nxt = 1'b0;
            end
         end
         ssgb_pkg::ST_CALC: begin
            st_nxt = ssgb_pkg::ST_IDLE;
            done_nxt = 1'b1;
            res_nxt.leaf = leaf;
            res_nxt.rsvd_err = rsvd_err;
            res_nxt.rd_ok = rd_ok_w;
            res_nxt.wr_ok = wr_ok_w;
            res_nxt.success = success;
            res_nxt.snoop = ctx_r.snoop_ctl_support && ent_r[ssgb_pkg::BIT_SNOOP];
            res_nxt.emt_used = emt_used_w;
            res_nxt.emt_rsvd = emt_rsvd_w;
            res_nxt.pat_used = pat_used_w;
            res_nxt.mem_type = mem_type_w;
            // walk stops here: base from the entry, offset from the input
            oaddr_nxt = success ? ((ent_r & HOST_MASK & ~ssgb_pkg::PAGE_OFS_MASK)
               | (iaddr_r & ssgb_pkg::PAGE_OFS_MASK)) : 64'h0;
            uent_nxt = ent_r;
            if (ctx_r.second_stage_ad_enable && success) begin
               uent_nxt[ssgb_pkg::BIT_ACCESSED] = 1'b1;
               if (req_r.is_write) begin
                  uent_nxt[ssgb_pkg::BIT_DIRTY] = 1'b1;
               end
            end
         end
         default: begin
            st_nxt = ssgb_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // all state frozen while the clock enable is low
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ack_r <= 1'b0;
         wait_r <= 1'b1;
         rdata_r <= ssgb_pkg::RST_WORD;
         ctx_r <= '0;
         req_r <= '0;
         ent_r <= 64'h0;
         iaddr_r <= 64'h0;
         st_r <= ssgb_pkg::ST_IDLE;
         res_r <= '0;
         done_r <= 1'b0;
         oaddr_r <= 64'h0;
         uent_r <= 64'h0;
      end else if (ce_i) begin
         ack_r <= ack_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         ctx_r <= ctx_nxt;
         req_r <= req_nxt;
         ent_r <= ent_nxt;
         iaddr_r <= iaddr_nxt;
         st_r <= st_nxt;
         res_r <= res_nxt;
         done_r <= done_nxt;
         oaddr_r <= oaddr_nxt;
         uent_r <= uent_nxt;
      end
   end

   assign avs_readdata_o = rdata_r;
   assign avs_waitrequest_o = wait_r;
   assign busy_o = (st_r == ssgb_pkg::ST_CALC);
   assign done_o = done_r;

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the captured result one edge after the calc cycle, and on the bus handshake
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   logic cap;
   assign cap = (st_r == ssgb_pkg::ST_CALC) && ce_i;

   a_leaf_decode: assert property (cap |=> res_r.leaf == ent_r[7])
      else $error("leaf flag does not follow page size bit");
   a_ps_reserved: assert property (cap && !ctx_r.second_stage_large_page_support
      && ent_r[7] |=> res_r.rsvd_err && !res_r.success)
      else $error("page size bit accepted without large page support");
   a_write_deny: assert property (cap && !ctx_r.io_rw_enable && !ent_r[1]
      |=> !res_r.wr_ok)
      else $error("write granted with write bit clear");
   a_read_deny: assert property (cap && !ctx_r.io_rw_enable && !ent_r[0]
      && !(ctx_r.zero_len_read_support && req_r.zero_len && ent_r[1]) |=> !res_r.rd_ok)
      else $error("read granted with read bit clear");
   a_io_perm: assert property (cap && ctx_r.io_rw_enable
      |=> res_r.wr_ok == ent_r[62] && (ent_r[61] -> res_r.rd_ok))
      else $error("io permission bits not honoured");
   a_zlr_skip: assert property (cap && ctx_r.zero_len_read_support && req_r.zero_len
      && (ctx_r.io_rw_enable ? ent_r[62] : ent_r[1]) |=> res_r.rd_ok)
      else $error("zero length read not exempted");
   a_dirty_set: assert property (cap && ctx_r.second_stage_ad_enable && success
      && req_r.is_write |=> uent_r[9] && uent_r[8])
      else $error("dirty or accessed not set after write translation");
   a_ad_ignore: assert property (cap && !ctx_r.second_stage_ad_enable
      |=> uent_r == ent_r)
      else $error("flags changed with access/dirty disabled");
   a_out_addr: assert property (cap && success
      |=> oaddr_r[29:0] == iaddr_r[29:0]
      && oaddr_r[63:30] == (ent_r[63:30] & HOST_MASK[63:30]))
      else $error("output address not base plus offset");
   a_emt_type: assert property (cap |=> res_r.emt_used
      -> (res_r.mem_type == ent_r[5:3]
          && res_r.emt_rsvd == !(ent_r[5:3] inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6})))
      else $error("memory type decode wrong");
   a_ignore_attr_table_bit_gate: assert property (cap && (!ctx_r.ext_mem_type_enable
      || ctx_r.table_mode == 2'h0 || ctx_r.translation_type != 3'h3) |=> res_r.pat_used)
      else $error("attribute table skipped outside nested walk");
   a_bus_answer: assert property ((avs_read_i || avs_write_i) && ce_i && !ack_r
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not after one wait state");
   a_snoop_gate: assert property (cap && !ctx_r.snoop_ctl_support |=> !res_r.snoop)
      else $error("snoop reported without snoop control");

   c_write_ok: cover property (cap && success && req_r.is_write);
   c_not_leaf: cover property (cap && !leaf);
   c_ignore_attr_table_bit_skip: cover property (cap && !pat_used_w);
   c_rsvd_fault: cover property (cap && rsvd_err);

endmodule

// file: src/ssgb_pkg.sv
// shared constants, register map and carrier types for the 1-GByte leaf entry decoder
package ssgb_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the avalon slave
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_CTX = 8'h04;
   localparam logic [7:0] OFF_ENT_LO = 8'h08;
   localparam logic [7:0] OFF_ENT_HI = 8'h0C;
   localparam logic [7:0] OFF_IADDR_LO = 8'h10;
   localparam logic [7:0] OFF_IADDR_HI = 8'h14;
   localparam logic [7:0] OFF_REQ = 8'h18;
   localparam logic [7:0] OFF_STAT = 8'h1C;
   localparam logic [7:0] OFF_OADDR_LO = 8'h20;
   localparam logic [7:0] OFF_OADDR_HI = 8'h24;
   localparam logic [7:0] OFF_UENT_LO = 8'h28;
   localparam logic [7:0] OFF_UENT_HI = 8'h2C;

   // command register bit
   localparam int unsigned CMD_START_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // entry field positions
   localparam int unsigned BIT_READ = 0;
   localparam int unsigned BIT_WRITE = 1;
   localparam int unsigned EMT_LO = 3;
   localparam int unsigned EMT_HI = 5;
   localparam int unsigned BIT_IGN_ATTR = 6;
   localparam int unsigned BIT_PAGE_SIZE = 7;
   localparam int unsigned BIT_ACCESSED = 8;
   localparam int unsigned BIT_DIRTY = 9;
   localparam int unsigned BIT_SNOOP = 11;
   localparam int unsigned BIT_IO_READ = 61;
   localparam int unsigned BIT_IO_WRITE = 62;
   localparam int unsigned RSV_TOP_BIT = 51;
   localparam logic [63:0] PAGE_OFS_MASK = 64'h0000_0000_3FFF_FFFF;
   localparam logic [63:0] RSV_LOW_MASK = 64'h0000_0000_3FFF_F000;
   localparam logic [63:0] RSV_TOP_MASK = 64'h000F_FFFF_FFFF_FFFF;

   // context encodings
   localparam logic [1:0] TTM_LEGACY = 2'h0;
   localparam logic [2:0] TRANSLATION_TYPE_SS_ONLY = 3'h2;
   localparam logic [2:0] TRANSLATION_TYPE_NESTED = 3'h3;

   // extended memory type encodings
   localparam logic [2:0] MT_UC = 3'h0;
   localparam logic [2:0] MT_WC = 3'h1;
   localparam logic [2:0] MT_WT = 3'h4;
   localparam logic [2:0] MT_WP = 3'h5;
   localparam logic [2:0] MT_WB = 3'h6;

   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // walk state
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CALC = 1'b1
   } ssgb_state_t;

   // context and capability settings, CTX register bits 11:0 (msb first)
   typedef struct packed {
      logic snoop_ctl_support;
      logic second_stage_large_page_support;
      logic zero_len_read_support;
      logic io_rw_enable;
      logic coherent_dev;
      logic [2:0] translation_type;
      logic [1:0] table_mode;
      logic ext_mem_type_enable;
      logic second_stage_ad_enable;
   } ssgb_ctx_t;

   // request kind, REQ register bits 2:0
   typedef struct packed {
      logic zero_len;
      logic is_write;
      logic is_read;
   } ssgb_req_t;

   // decode result, STAT register bits 11:0
   typedef struct packed {
      logic [2:0] mem_type;
      logic pat_used;
      logic emt_rsvd;
      logic emt_used;
      logic snoop;
      logic success;
      logic wr_ok;
      logic rd_ok;
      logic rsvd_err;
      logic leaf;
   } ssgb_res_t;

   localparam int unsigned STAT_DONE_BIT = 12;

endpackage

// file: src/ssgb_perm.sv
// read and write permission decode of a 1-GByte leaf entry
`timescale 1ns/1ns
module ssgb_perm (
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // entry and request
   input wire logic [63:0] entry_i,
   input wire ssgb_pkg::ssgb_ctx_t ctx_i,
   input wire ssgb_pkg::ssgb_req_t req_i,
   // decisions
   output logic rd_ok_o,
   output logic wr_ok_o
);

   logic rd_ok_r;
   logic rd_ok_nxt;
   logic wr_ok_r;
   logic wr_ok_nxt;
   logic wbit;
   logic rbit;
   logic zlr_skip;

   // pick the active bit pair, then exempt zero-length reads
   always_comb begin
      wbit = ctx_i.io_rw_enable ? entry_i[ssgb_pkg::BIT_IO_WRITE]
                                : entry_i[ssgb_pkg::BIT_WRITE];
      rbit = ctx_i.io_rw_enable ? entry_i[ssgb_pkg::BIT_IO_READ]
                                : entry_i[ssgb_pkg::BIT_READ];
      // read check waived only when the granting write bit is set
      zlr_skip = ctx_i.zero_len_read_support && req_i.zero_len && wbit;
      wr_ok_nxt = wbit;
      rd_ok_nxt = rbit || zlr_skip;
   end

   // registered decisions
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rd_ok_r <= 1'b0;
         wr_ok_r <= 1'b0;
      end else if (ce_i) begin
         rd_ok_r <= rd_ok_nxt;
         wr_ok_r <= wr_ok_nxt;
      end
   end

   assign rd_ok_o = rd_ok_r;
   assign wr_ok_o = wr_ok_r;

endmodule

// file: src/ssgb_memtype.sv
// extended memory type and attribute table use for a 1-GByte leaf entry
`timescale 1ns/1ns
module ssgb_memtype (
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // entry and context
   input wire logic [63:0] entry_i,
   input wire ssgb_pkg::ssgb_ctx_t ctx_i,
   // results
   output logic emt_used_o,
   output logic emt_rsvd_o,
   output logic pat_used_o,
   output logic [2:0] mem_type_o
);

   logic emt_used_r;
   logic emt_used_nxt;
   logic emt_rsvd_r;
   logic emt_rsvd_nxt;
   logic pat_used_r;
   logic pat_used_nxt;
   logic [2:0] mem_type_r;
   logic [2:0] mem_type_nxt;
   logic ignore_attr_table_bit_act;
   logic [2:0] code;
   logic code_ok;

   // field only counts for coherent-domain second-stage-only or nested walks
   always_comb begin
      code = entry_i[ssgb_pkg::EMT_HI:ssgb_pkg::EMT_LO];
      emt_used_nxt = ctx_i.ext_mem_type_enable && ctx_i.coherent_dev
         && (ctx_i.table_mode != ssgb_pkg::TTM_LEGACY)
         && ((ctx_i.translation_type == ssgb_pkg::TRANSLATION_TYPE_SS_ONLY)
             || (ctx_i.translation_type == ssgb_pkg::TRANSLATION_TYPE_NESTED));
      ignore_attr_table_bit_act = emt_used_nxt
         && (ctx_i.translation_type == ssgb_pkg::TRANSLATION_TYPE_NESTED);
      pat_used_nxt = !(ignore_attr_table_bit_act && entry_i[ssgb_pkg::BIT_IGN_ATTR]);
      code_ok = (code == ssgb_pkg::MT_UC) || (code == ssgb_pkg::MT_WC)
         || (code == ssgb_pkg::MT_WT) || (code == ssgb_pkg::MT_WP)
         || (code == ssgb_pkg::MT_WB);
      emt_rsvd_nxt = emt_used_nxt && !code_ok;
      // an ignored field reports uncacheable rather than stale bits
      mem_type_nxt = emt_used_nxt ? code : ssgb_pkg::MT_UC;
   end

   // registered results
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         emt_used_r <= 1'b0;
         emt_rsvd_r <= 1'b0;
         pat_used_r <= 1'b1;
         mem_type_r <= 3'h0;
      end else if (ce_i) begin
         emt_used_r <= emt_used_nxt;
         emt_rsvd_r <= emt_rsvd_nxt;
         pat_used_r <= pat_used_nxt;
         mem_type_r <= mem_type_nxt;
      end
   end

   assign emt_used_o = emt_used_r;
   assign emt_rsvd_o = emt_rsvd_r;
   assign pat_used_o = pat_used_r;
   assign mem_type_o = mem_type_r;

endmodule

// file: testbench/ssgb_dma_model.sv
// dma requester model: request kind and input address per selector
`timescale 1ns/1ns
module ssgb_dma_model (
   // request select
   input wire logic [1:0] sel_i,
   // request presented for translation
   output logic [2:0] req_o,
   output logic [31:0] iaddr_o
);
   // top address bits set on purpose so the page offset mask is exercised
   assign iaddr_o = 32'hD234_5678;
   // 0 read, 1 write, 2 zero-length read
   assign req_o = (sel_i == 2'h0) ? 3'h1 : ((sel_i == 2'h1) ? 3'h2 : 3'h5);
endmodule

// file: testbench/test_ssgb_top.sv
// self-checking bench for the 1-GByte leaf entry decoder
`timescale 1ns/1ns
module test_ssgb_top;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [31:0] avs_readdata_o, rd, iaddr;
   logic avs_waitrequest_o, busy_o, done_o;
   logic [1:0] sel = 2'h0;
   logic [2:0] req;
   int mismatches = 0;
   int n_checks = 0;
   // 20 MHz clock
   always #25 clk_sys_i = ~clk_sys_i;
   ssgb_top ssgb_top_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .busy_o(busy_o), .done_o(done_o));
   ssgb_dma_model ssgb_dma_model_i (.sel_i(sel), .req_o(req), .iaddr_o(iaddr));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      // idle edge first, so a new request never lands on the previous release
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      @(posedge clk_sys_i);
      while (avs_waitrequest_o !== 1'b0) begin
         @(posedge clk_sys_i);
      end
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   // load context, entry, request; start; wait for done; fetch status
   task automatic decode(input logic [31:0] ctx, lo, hi, input logic [1:0] s);
      sel <= s;
      bus(1'b1, ssgb_pkg::OFF_CTX, ctx);
      bus(1'b1, ssgb_pkg::OFF_ENT_LO, lo);
      bus(1'b1, ssgb_pkg::OFF_ENT_HI, hi);
      bus(1'b1, ssgb_pkg::OFF_IADDR_LO, iaddr);
      bus(1'b1, ssgb_pkg::OFF_REQ, {29'h0, req});
      bus(1'b1, ssgb_pkg::OFF_CMD, 32'h0000_0001);
      // old done is still visible at the start edge, so skip it
      @(posedge clk_sys_i);
      check("busy", {31'h0, busy_o}, 32'h1);
      while (done_o !== 1'b1) begin
         @(posedge clk_sys_i);
      end
      check("busy_end", {31'h0, busy_o}, 32'h0);
      bus(1'b0, ssgb_pkg::OFF_STAT, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_read_leaf;
      decode(32'h0000_0401, 32'h4000_0081, 32'h0000_0001, 2'h0);
      check("stat", rd & 32'h1F, 32'h15);
      bus(1'b0, ssgb_pkg::OFF_OADDR_LO, 32'h0);
      check("oaddr_lo", rd, 32'h5234_5678);
      bus(1'b0, ssgb_pkg::OFF_OADDR_HI, 32'h0);
      check("oaddr_hi", rd, 32'h0000_0001);
      bus(1'b0, ssgb_pkg::OFF_UENT_LO, 32'h0);
      check("uent_lo", rd, 32'h4000_0181);
      bus(1'b0, 8'h40, 32'h0);
      check("unmapped", rd, 32'h0);
   endtask
   task automatic t_write_denied;
      decode(32'h0000_0401, 32'h4000_0081, 32'h0000_0001, 2'h1);
      check("stat", rd & 32'h1F, 32'h05);
      bus(1'b0, ssgb_pkg::OFF_UENT_LO, 32'h0);
      check("uent_lo", rd, 32'h4000_0081);
   endtask
   task automatic t_io_write;
      decode(32'h0000_0501, 32'h4000_0080, 32'h4000_0001, 2'h1);
      check("stat", rd & 32'h1F, 32'h19);
      bus(1'b0, ssgb_pkg::OFF_UENT_LO, 32'h0);
      check("uent_lo", rd, 32'h4000_0380);
      decode(32'h0000_0500, 32'h4000_0083, 32'h0000_0001, 2'h0);
      check("stat", rd & 32'h1F, 32'h01);
   endtask
   task automatic t_ad_off;
      decode(32'h0000_0400, 32'h4000_0081, 32'h0000_0001, 2'h0);
      bus(1'b0, ssgb_pkg::OFF_UENT_LO, 32'h0);
      check("uent_lo", rd, 32'h4000_0081);
   endtask
   task automatic t_page_size;
      decode(32'h0000_0401, 32'h4000_0001, 32'h0000_0001, 2'h0);
      check("leaf", rd & 32'h3, 32'h0);
      decode(32'h0000_0001, 32'h4000_0081, 32'h0000_0001, 2'h0);
      check("rsvd", rd & 32'h3, 32'h3);
   endtask
   task automatic t_zero_len;
      decode(32'h0000_0601, 32'h4000_0082, 32'h0000_0001, 2'h2);
      check("rd_ok", rd & 32'h4, 32'h4);
      decode(32'h0000_0401, 32'h4000_0082, 32'h0000_0001, 2'h2);
      check("rd_ok", rd & 32'h4, 32'h0);
   endtask
   // every type code, nested coherent walk with attribute table ignored; then legacy, second-stage-only and attribute-table-used cases
   task automatic t_mem_type;
      logic rsv;
      for (int c = 0; c < 8; c++) begin
         rsv = !(c inside {0, 1, 4, 5, 6});
         decode(32'h0000_04B6, 32'h4000_00C1 | (c << 3), 32'h1, 2'h0);
         check("mtype", rd & 32'hFC0, {20'h0, c[2:0], 1'b0, rsv, 7'h40});
      end
      decode(32'h0000_04B2, 32'h4000_00F1, 32'h1, 2'h0);
      check("legacy", rd & 32'hFC0, 32'h100);
      decode(32'h0000_04A6, 32'h4000_00C1, 32'h1, 2'h0);
      check("ss_only", rd & 32'h1C0, 32'h140);
      decode(32'h0000_04B6, 32'h4000_00B1, 32'h1, 2'h0);
      check("pat", rd & 32'hFC0, 32'hD40);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // reset for 8 cycles, then the scenarios
   initial begin
      repeat (8) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_sys_i);
      t_read_leaf();
      t_write_denied();
      t_io_write();
      t_ad_off();
      t_page_size();
      t_zero_len();
      t_mem_type();
      stop_test();
   end
   // watchdog, far beyond the roughly 500 cycles the scenarios need
   initial begin
      #500000;
      mismatches++;
      stop_test();
   end
endmodule
